// ===== inc/atl_defines.vh
// register map, field positions, reset values and widths of the alert / threshold block
// assumes a 16-bit internal register port with a 4-bit word index
`ifndef ATL_DEFINES_VH
`define ATL_DEFINES_VH

`define ATL_ADDR_W          4
`define ATL_DATA_W          16
`define ATL_FLAG_W          16

`define ATL_OFS_LIMIT_EN    4'h2
`define ATL_OFS_ALERT_CFG   4'h3
`define ATL_OFS_X_THR       4'h4
`define ATL_OFS_Y_THR       4'h5
`define ATL_OFS_Z_THR       4'h6
`define ATL_OFS_T_THR       4'h7

`define ATL_RST_LIMIT_EN    16'h0000
`define ATL_RST_ALERT_CFG   16'h0000
`define ATL_RST_X_THR       16'h7D83
`define ATL_RST_Y_THR       16'h7D83
`define ATL_RST_Z_THR       16'h7D83
`define ATL_RST_T_THR       16'h6732

`define ATL_MASK_LIMIT_EN   16'h0007
`define ATL_MASK_ALERT_CFG  16'h393F

`define ATL_BIT_X_LIMIT     0
`define ATL_BIT_Y_LIMIT     1
`define ATL_BIT_Z_LIMIT     2

`define ATL_BIT_HOLD        13
`define ATL_BIT_SWITCH      12
`define ATL_BIT_STATUS_EN   11
`define ATL_BIT_RESULT_EN   8
`define ATL_FLD_COUNT_HI    5
`define ATL_FLD_COUNT_LO    4
`define ATL_BIT_T_ALERT     3
`define ATL_BIT_Z_ALERT     2
`define ATL_BIT_Y_ALERT     1
`define ATL_BIT_X_ALERT     0

`define ATL_FLD_UPPER_HI    15
`define ATL_FLD_UPPER_LO    8
`define ATL_FLD_LOWER_HI    7
`define ATL_FLD_LOWER_LO    0

`define ATL_STATE_NONE      2'h0
`define ATL_STATE_FRONTEND  2'h1
`define ATL_STATE_SYSTEM    2'h2
`define ATL_STATE_BOTH      2'h3

`endif

// ===== hdl/atl_axis_check.v
// one channel of limit checking: counts consecutive out-of-band conversions
// assumes samples are 16-bit two's complement scaled to the channel's full scale
`timescale 1ns/1ps
`default_nettype none

module atl_axis_check (
	input  wire        ref_clk,
	input  wire        rst_n,
	input  wire        check_en,
	input  wire        sample_valid,
	input  wire [15:0] sample,
	input  wire [7:0]  upper_limit,
	input  wire [7:0]  lower_limit,
	input  wire [1:0]  count_required,
	output reg         crossed_r
);

	reg  [2:0] hits_r;
	wire       above;
	wire       below;
	wire       outside;

	// one limit step is full scale / 128, i.e. 256 sample codes
	assign above   = $signed(sample) > $signed({upper_limit, 8'h00});
	assign below   = $signed(sample) < $signed({lower_limit, 8'h00});
	assign outside = above | below;

	always @(posedge ref_clk) begin
		if (!rst_n) begin
			hits_r    <= 3'h0;
			crossed_r <= 1'b0;
		end else if (!check_en) begin
			hits_r    <= 3'h0;
			crossed_r <= 1'b0;
		end else if (sample_valid) begin
			if (outside) begin
				// field value plus one conversions are needed before the flag rises
				if (hits_r >= {1'b0, count_required}) begin
					crossed_r <= 1'b1;
				end else begin
					hits_r <= hits_r + 3'h1;
				end
			end else begin
				hits_r    <= 3'h0;
				crossed_r <= 1'b0;
			end
		end
	end

endmodule // atl_axis_check

`default_nettype wire

// ===== hdl/atl_source_hold.v
// one alert source: passes the level through, or holds it until a clearing read
// assumes the clear is a one-cycle pulse from the register read path
`timescale 1ns/1ps
`default_nettype none

module atl_source_hold (
	input  wire ref_clk,
	input  wire rst_n,
	input  wire hold_en,
	input  wire source,
	input  wire clear,
	output wire active
);

	reg held_r;
	reg held_nxt;

	always @* begin
		// a source present in the clearing cycle keeps the hold set
		held_nxt = source | (held_r & ~clear);
		if (!hold_en) begin
			held_nxt = 1'b0;
		end
	end

	always @(posedge ref_clk) begin
		if (!rst_n) begin
			held_r <= 1'b0;
		end else begin
			held_r <= held_nxt;
		end
	end

	assign active = source | (hold_en & held_r);

endmodule // atl_source_hold

`default_nettype wire

// ===== hdl/atl_top.v
// alert generation and magnetic / temperature limit checking
// assumes the serial front end supplies word-indexed register strobes, sample
// strobes from the conversion path and one-cycle pulses on status/result reads
//
// Function
// - hold bit 0: alert follows enabled sources, drops when they vanish.
// - hold bit 1: alert stays until host reads matching status or result.
// - switch mode overrides interrupts, blocks alert triggers, follows axis crossings.
// - status enable makes any frontend or system flag assert alert.
// - result enable makes completed conversion set assert alert.
// - threshold alert needs count field plus one conversions outside limits.
// - temperature enable lets temperature crossings assert alert.
// - per-axis enables let X, Y, Z crossings assert alert.
// - X limits register: upper limit high byte, lower limit low byte.
// - one limit step equals the axis full scale divided by 128.
// - X limits reset to upper 7Dh and lower 83h.
// - per-axis limit check enable turns comparison on, default off.
// - state field: 0 none, 1 frontend, 2 system, 3 both.
`timescale 1ns/1ps
`default_nettype none
`include "atl_defines.vh"

module atl_top (
	input  wire                      ref_clk,
	input  wire                      rst_n,
	input  wire                      reg_wr,
	input  wire                      reg_rd,
	input  wire [`ATL_ADDR_W-1:0]    reg_addr,
	input  wire [`ATL_DATA_W-1:0]    reg_wdata,
	output reg  [`ATL_DATA_W-1:0]    reg_rdata,
	input  wire                      sample_valid,
	input  wire [15:0]               x_field,
	input  wire [15:0]               y_field,
	input  wire [15:0]               z_field,
	input  wire [7:0]                temp_code,
	input  wire                      set_done,
	input  wire [`ATL_FLAG_W-1:0]    frontend_fault_flags,
	input  wire [`ATL_FLAG_W-1:0]    system_fault_flags,
	input  wire                      frontend_status_read,
	input  wire                      system_status_read,
	input  wire                      result_read,
	output reg                       alert_n,
	output reg                       alert_trigger_enable,
	output reg  [1:0]                alert_state_field
);

	// configuration registers
	reg  [`ATL_DATA_W-1:0] limit_en_r;
	reg  [`ATL_DATA_W-1:0] alert_cfg_r;
	reg  [`ATL_DATA_W-1:0] x_thr_r;
	reg  [`ATL_DATA_W-1:0] y_thr_r;
	reg  [`ATL_DATA_W-1:0] z_thr_r;
	reg  [`ATL_DATA_W-1:0] t_thr_r;
	reg  [`ATL_DATA_W-1:0] rdata_nxt;

	// decoded fields
	wire                   hold_sel;
	wire                   switch_sel;
	wire                   status_alert_enable;
	wire                   result_alert_enable;
	wire [1:0]             crossing_count_required;
	wire                   temperature_threshold_alert_enable;
	wire                   z_threshold_alert_enable;
	wire                   y_threshold_alert_enable;
	wire                   x_threshold_alert_enable;
	wire                   x_limit_check_enable;
	wire                   y_limit_check_enable;
	wire                   z_limit_check_enable;

	// channel results
	wire                   x_crossed;
	wire                   y_crossed;
	wire                   z_crossed;
	wire                   t_crossed;

	// alert sources
	wire                   frontend_any;
	wire                   system_any;
	wire                   status_src;
	wire                   result_src;
	wire                   threshold_src;
	wire                   switch_src;
	wire                   status_active;
	wire                   result_active;
	wire                   threshold_active;
	wire                   interrupt_level;
	wire                   alert_level;
	wire                   status_clear;

	// true when a write strobe targets the given word index
	function wr_hit;
		input                   wr;
		input [`ATL_ADDR_W-1:0] addr;
		input [`ATL_ADDR_W-1:0] ofs;
		begin
			wr_hit = wr & (addr == ofs);
		end
	endfunction

	// upper or lower byte of a limits word
	function [7:0] upper_of;
		input [`ATL_DATA_W-1:0] word;
		begin
			upper_of = word[`ATL_FLD_UPPER_HI:`ATL_FLD_UPPER_LO];
		end
	endfunction

	function [7:0] lower_of;
		input [`ATL_DATA_W-1:0] word;
		begin
			lower_of = word[`ATL_FLD_LOWER_HI:`ATL_FLD_LOWER_LO];
		end
	endfunction

	// register writes
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			limit_en_r  <= `ATL_RST_LIMIT_EN;
			alert_cfg_r <= `ATL_RST_ALERT_CFG;
			x_thr_r     <= `ATL_RST_X_THR;
			y_thr_r     <= `ATL_RST_Y_THR;
			z_thr_r     <= `ATL_RST_Z_THR;
			t_thr_r     <= `ATL_RST_T_THR;
		end else begin
			if (wr_hit(reg_wr, reg_addr, `ATL_OFS_LIMIT_EN)) begin
				limit_en_r <= reg_wdata & `ATL_MASK_LIMIT_EN;
			end
			if (wr_hit(reg_wr, reg_addr, `ATL_OFS_ALERT_CFG)) begin
				// reserved bits are never stored, so they cannot steer anything
				alert_cfg_r <= reg_wdata & `ATL_MASK_ALERT_CFG;
			end
			if (wr_hit(reg_wr, reg_addr, `ATL_OFS_X_THR)) begin
				x_thr_r <= reg_wdata;
			end
			if (wr_hit(reg_wr, reg_addr, `ATL_OFS_Y_THR)) begin
				y_thr_r <= reg_wdata;
			end
			if (wr_hit(reg_wr, reg_addr, `ATL_OFS_Z_THR)) begin
				z_thr_r <= reg_wdata;
			end
			if (wr_hit(reg_wr, reg_addr, `ATL_OFS_T_THR)) begin
				t_thr_r <= reg_wdata;
			end
		end
	end

	// register reads; unmapped indices return zero
	always @* begin
		rdata_nxt = {`ATL_DATA_W{1'b0}};
		case (reg_addr)
			`ATL_OFS_LIMIT_EN: begin
				rdata_nxt = limit_en_r;
			end
			`ATL_OFS_ALERT_CFG: begin
				rdata_nxt = alert_cfg_r & `ATL_MASK_ALERT_CFG;
			end
			`ATL_OFS_X_THR: begin
				rdata_nxt = x_thr_r;
			end
			`ATL_OFS_Y_THR: begin
				rdata_nxt = y_thr_r;
			end
			`ATL_OFS_Z_THR: begin
				rdata_nxt = z_thr_r;
			end
			`ATL_OFS_T_THR: begin
				rdata_nxt = t_thr_r;
			end
			default: begin
				rdata_nxt = {`ATL_DATA_W{1'b0}};
			end
		endcase
	end

	always @(posedge ref_clk) begin
		if (!rst_n) begin
			reg_rdata <= {`ATL_DATA_W{1'b0}};
		end else if (reg_rd) begin
			reg_rdata <= rdata_nxt;
		end
	end

	// field decode
	assign hold_sel                           = alert_cfg_r[`ATL_BIT_HOLD];
	assign switch_sel                         = alert_cfg_r[`ATL_BIT_SWITCH];
	assign status_alert_enable                = alert_cfg_r[`ATL_BIT_STATUS_EN];
	assign result_alert_enable                = alert_cfg_r[`ATL_BIT_RESULT_EN];
	assign crossing_count_required            = alert_cfg_r[`ATL_FLD_COUNT_HI:`ATL_FLD_COUNT_LO];
	assign temperature_threshold_alert_enable = alert_cfg_r[`ATL_BIT_T_ALERT];
	assign z_threshold_alert_enable           = alert_cfg_r[`ATL_BIT_Z_ALERT];
	assign y_threshold_alert_enable           = alert_cfg_r[`ATL_BIT_Y_ALERT];
	assign x_threshold_alert_enable           = alert_cfg_r[`ATL_BIT_X_ALERT];
	assign x_limit_check_enable               = limit_en_r[`ATL_BIT_X_LIMIT];
	assign y_limit_check_enable               = limit_en_r[`ATL_BIT_Y_LIMIT];
	assign z_limit_check_enable               = limit_en_r[`ATL_BIT_Z_LIMIT];

	// per-channel limit checks
	atl_axis_check u_x_check (
		.ref_clk        (ref_clk),
		.rst_n          (rst_n),
		.check_en       (x_limit_check_enable),
		.sample_valid   (sample_valid),
		.sample         (x_field),
		.upper_limit    (upper_of(x_thr_r)),
		.lower_limit    (lower_of(x_thr_r)),
		.count_required (crossing_count_required),
		.crossed_r      (x_crossed)
	);

	atl_axis_check u_y_check (
		.ref_clk        (ref_clk),
		.rst_n          (rst_n),
		.check_en       (y_limit_check_enable),
		.sample_valid   (sample_valid),
		.sample         (y_field),
		.upper_limit    (upper_of(y_thr_r)),
		.lower_limit    (lower_of(y_thr_r)),
		.count_required (crossing_count_required),
		.crossed_r      (y_crossed)
	);

	atl_axis_check u_z_check (
		.ref_clk        (ref_clk),
		.rst_n          (rst_n),
		.check_en       (z_limit_check_enable),
		.sample_valid   (sample_valid),
		.sample         (z_field),
		.upper_limit    (upper_of(z_thr_r)),
		.lower_limit    (lower_of(z_thr_r)),
		.count_required (crossing_count_required),
		.crossed_r      (z_crossed)
	);

	// temperature has no separate check enable; its alert enable gates it
	atl_axis_check u_t_check (
		.ref_clk        (ref_clk),
		.rst_n          (rst_n),
		.check_en       (temperature_threshold_alert_enable),
		.sample_valid   (sample_valid),
		.sample         ({temp_code, 8'h00}),
		.upper_limit    (upper_of(t_thr_r)),
		.lower_limit    (lower_of(t_thr_r)),
		.count_required (crossing_count_required),
		.crossed_r      (t_crossed)
	);

	// source levels
	assign frontend_any  = |frontend_fault_flags;
	assign system_any    = |system_fault_flags;
	assign status_src    = status_alert_enable & (frontend_any | system_any);
	assign result_src    = result_alert_enable & set_done;
	assign threshold_src = (x_threshold_alert_enable & x_crossed)
	                     | (y_threshold_alert_enable & y_crossed)
	                     | (z_threshold_alert_enable & z_crossed)
	                     | (temperature_threshold_alert_enable & t_crossed);
	// switch output relies on the host having enabled the axis limit checks
	assign switch_src    = (x_threshold_alert_enable & x_crossed)
	                     | (y_threshold_alert_enable & y_crossed)
	                     | (z_threshold_alert_enable & z_crossed);
	assign status_clear  = frontend_status_read | system_status_read;

	atl_source_hold u_status_hold (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.hold_en (hold_sel),
		.source  (status_src),
		.clear   (status_clear),
		.active  (status_active)
	);

	// threshold crossings are reported with the results, so a result read clears both
	atl_source_hold u_result_hold (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.hold_en (hold_sel),
		.source  (result_src),
		.clear   (result_read),
		.active  (result_active)
	);

	atl_source_hold u_threshold_hold (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.hold_en (hold_sel),
		.source  (threshold_src),
		.clear   (result_read),
		.active  (threshold_active)
	);

	assign interrupt_level = status_active | result_active | threshold_active;
	assign alert_level     = switch_sel ? switch_src : interrupt_level;

	// outputs all come from flops so the pin never glitches on decode
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			alert_n              <= 1'b1;
			alert_trigger_enable <= 1'b1;
			alert_state_field    <= `ATL_STATE_NONE;
		end else begin
			alert_n              <= ~alert_level;
			alert_trigger_enable <= ~switch_sel;
			case ({system_any, frontend_any})
				2'b01: begin
					alert_state_field <= `ATL_STATE_FRONTEND;
				end
				2'b10: begin
					alert_state_field <= `ATL_STATE_SYSTEM;
				end
				2'b11: begin
					alert_state_field <= `ATL_STATE_BOTH;
				end
				default: begin
					alert_state_field <= `ATL_STATE_NONE;
				end
			endcase
		end
	end

endmodule // atl_top

`default_nettype wire

// ===== verif/atl_top_sva.sv
// concurrent checks on the alert / limit block, bound to atl_top
// assumes the alert config word changes only through the register port
`timescale 1ns/1ps
`default_nettype none
`include "atl_defines.vh"
module atl_top_chk (
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [3:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic        set_done,
	input wire logic [15:0] frontend_fault_flags,
	input wire logic [15:0] system_fault_flags,
	input wire logic        frontend_status_read,
	input wire logic        system_status_read,
	input wire logic        result_read,
	input wire logic        alert_n,
	input wire logic        alert_trigger_enable,
	input wire logic [1:0]  alert_state_field
);
	logic [15:0] cfg_r;
	logic        rd_any;
	assign rd_any = frontend_status_read | system_status_read | result_read;
	// shadow of the config word, written in step with the device
	always @(posedge ref_clk)
		if (!rst_n)
			cfg_r <= 16'h0000;
		else if (reg_wr && reg_addr == 4'h3)
			cfg_r <= reg_wdata;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_reset_idle: assert property (disable iff (1'b0) !rst_n |=> alert_n && alert_trigger_enable
		&& alert_state_field == 2'h0 && reg_rdata == 16'h0000) else $error("outputs not idle in reset");
	a_state_flags: assert property ($past(rst_n) |-> alert_state_field ==
		{|$past(system_fault_flags), |$past(frontend_fault_flags)}) else $error("state field wrong");
	a_trig_switch: assert property ($past(rst_n) |-> alert_trigger_enable == !$past(cfg_r[12]))
		else $error("trigger enable wrong");
	a_switch_masks: assert property (cfg_r[12] && cfg_r[2:0] == 3'h0 |=> alert_n)
		else $error("switch alert without axis enable");
	a_status_fires: assert property (cfg_r[11] && !cfg_r[12] &&
		(|frontend_fault_flags || |system_fault_flags) |=> !alert_n) else $error("status alert missing");
	a_result_fires: assert property (cfg_r[8] && !cfg_r[12] && set_done |=> !alert_n)
		else $error("result alert missing");
	a_quiet_idle: assert property ((cfg_r & 16'h390F) == 16'h0000 |=> alert_n)
		else $error("alert with no source enabled");
	a_hold_keeps: assert property (cfg_r[13] && !cfg_r[12] && $stable(cfg_r) && !alert_n
		&& !rd_any && !$past(rd_any) |=> !alert_n) else $error("held alert dropped");
	a_rdata_stands: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved");
	a_cfg_readback: assert property (reg_rd && reg_addr == 4'h3 |=>
		reg_rdata == ($past(cfg_r) & `ATL_MASK_ALERT_CFG)) else $error("config read wrong");
	c_held: cover property (cfg_r[13] && !alert_n);
	c_switch: cover property (cfg_r[12] && !alert_n);
	c_both: cover property (alert_state_field == 2'h3);
endmodule // atl_top_chk
bind atl_top atl_top_chk u_atl_top_chk (.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .set_done(set_done),
	.frontend_fault_flags(frontend_fault_flags), .system_fault_flags(system_fault_flags),
	.frontend_status_read(frontend_status_read), .system_status_read(system_status_read),
	.result_read(result_read), .alert_n(alert_n), .alert_trigger_enable(alert_trigger_enable),
	.alert_state_field(alert_state_field));
`default_nettype wire

// ===== verif/atl_host_model.sv
// host-side model: register accesses and status / result read pulses
// assumes the shared clock; drives on the falling edge
`timescale 1ns/1ps
`default_nettype none
module atl_host_model (
	input  wire logic        ref_clk,
	input  wire logic [15:0] reg_rdata,
	output var  logic        reg_wr,
	output var  logic        reg_rd,
	output var  logic [3:0]  reg_addr,
	output var  logic [15:0] reg_wdata,
	output var  logic [2:0]  rd_pulse
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		rd_pulse = 3'h0;
	end
	// released lines flip so stale data never passes for fresh
	task automatic release_bus;
		reg_addr = ~reg_addr;
		reg_wdata = ~reg_wdata;
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(negedge ref_clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge ref_clk);
		reg_wr = 1'b0;
		release_bus();
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(negedge ref_clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge ref_clk);
		reg_rd = 1'b0;
		release_bus();
		d = reg_rdata;
	endtask
	// 0 frontend, 1 system, 2 result read; clears a held alert
	task automatic clr(input int k);
		@(negedge ref_clk);
		rd_pulse = 3'h1 << k;
		@(negedge ref_clk);
		rd_pulse = 3'h0;
	endtask
endmodule // atl_host_model
`default_nettype wire

// ===== verif/atl_top_test.sv
// self-checking bench for atl_top, host model on the register port
// assumes atl_top, its checker and atl_host_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module atl_top_test;
	logic        ref_clk;
	logic        rst_n;
	logic        reg_wr;
	logic        reg_rd;
	logic [3:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic        sample_valid;
	logic [15:0] fld [3];
	logic        set_done;
	logic [15:0] fe_flags;
	logic [15:0] sys_flags;
	logic [7:0]  tcode;
	logic [2:0]  rd_pulse;
	logic        alert_n;
	logic        trig_en;
	logic [1:0]  state;
	logic [15:0] rdv;
	logic [15:0] mdl [16];
	integer      num_errors;
	integer      check_count;
	integer      seed;
	integer      run;
	integer      v;
	integer      ax;
	atl_top u_atl_top (.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
		.x_field(fld[0]), .y_field(fld[1]), .z_field(fld[2]), .temp_code(tcode), .set_done(set_done),
		.frontend_fault_flags(fe_flags), .system_fault_flags(sys_flags),
		.frontend_status_read(rd_pulse[0]), .system_status_read(rd_pulse[1]), .result_read(rd_pulse[2]),
		.alert_n(alert_n), .alert_trigger_enable(trig_en), .alert_state_field(state));
	atl_host_model u_atl_host_model (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .rd_pulse(rd_pulse));
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count = check_count + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// stored bits per word; unmapped words keep nothing
	function automatic logic [15:0] msk(input logic [3:0] a);
		case (a)
			4'h2: msk = 16'h0007;
			4'h3: msk = 16'h393F;
			4'h4, 4'h5, 4'h6, 4'h7: msk = 16'hFFFF;
			default: msk = 16'h0000;
		endcase
	endfunction
	task automatic mwr(input logic [3:0] a, input logic [15:0] d);
		u_atl_host_model.wr(a, d);
		mdl[a] = d & msk(a);
	endtask
	task automatic samp(input int a, input int x);
		@(negedge ref_clk);
		sample_valid = 1'b1;
		fld[a] = 16'(x);
		@(negedge ref_clk);
		sample_valid = 1'b0;
		fld[a] = ~fld[a];
	endtask
	task automatic pause(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	initial begin
		repeat (50000) @(posedge ref_clk);
		num_errors = num_errors + 1;
		final_report();
	end
	initial begin
		seed = 38223;
		rst_n = 1'b0;
		sample_valid = 1'b0;
		fld = '{16'h0000, 16'h0000, 16'h0000};
		set_done = 1'b0;
		fe_flags = 16'h0000;
		sys_flags = 16'h0000;
		tcode = 8'h18;
		num_errors = 0;
		check_count = 0;
		for (int i = 0; i < 16; i++)
			mdl[i] = (i > 3 && i < 7) ? 16'h7D83 : (i == 7) ? 16'h6732 : 16'h0000;
		pause(16);
		rst_n = 1'b1;
		for (int i = 0; i < 32; i++) begin
			if (i > 15)
				mwr(i[3:0], 16'($random(seed)));
			u_atl_host_model.rd(i[3:0], rdv);
			check(rdv, mdl[i[3:0]]);
		end
		// consecutive-crossing count on each axis, all four counts
		for (int k = 0; k < 4; k++) begin
			ax = k % 3;
			mwr(4'h2, 16'h0001 << ax);
			mwr(4'(4 + ax), 16'h10F0);
			mwr(4'h3, 16'(k << 4) | (16'h0001 << ax));
			run = 0;
			for (int n = 0; n < 24; n++) begin
				v = 4000 + $random(seed) % 200;
				if ($random(seed) & 1)
					v = -v;
				samp(ax, v);
				run = (v > 4096 || v < -4096) ? run + 1 : 0;
				pause(1);
				check(16'(alert_n), 16'(run <= k));
			end
			samp(ax, 0);
		end
		mwr(4'h3, 16'h0001);
		mwr(4'h2, 16'h0000);
		samp(0, 5000);
		pause(1);
		check(16'(alert_n), 16'h0001);
		for (int k = 0; k < 8; k++) begin
			mwr(4'h3, k[2] ? 16'h0800 : 16'h0000);
			fe_flags = k[0] ? (16'($random(seed)) | 16'h0001) : 16'h0000;
			sys_flags = k[1] ? 16'h8000 : 16'h0000;
			pause(2);
			check(16'(state), 16'(k[1:0]));
			check(16'(alert_n), 16'(!(k[2] && k[1:0] != 0)));
		end
		fe_flags = 16'h0000;
		sys_flags = 16'h0000;
		pause(2);
		check(16'(alert_n), 16'h0001);
		mwr(4'h3, 16'h2800);
		fe_flags = 16'h0004;
		pause(1);
		fe_flags = 16'h0000;
		pause(4);
		check(16'(alert_n), 16'h0000);
		u_atl_host_model.clr(0);
		pause(2);
		check(16'(alert_n), 16'h0001);
		for (int k = 0; k < 2; k++) begin
			mwr(4'h3, k ? 16'h2100 : 16'h0100);
			pause(1);
			set_done = 1'b1;
			pause(1);
			set_done = 1'b0;
			check(16'(alert_n), 16'h0000);
			pause(3);
			check(16'(alert_n), 16'(k == 0));
			u_atl_host_model.clr(2);
			pause(2);
			check(16'(alert_n), 16'h0001);
		end
		mwr(4'h2, 16'h0001);
		mwr(4'h4, 16'h10F0);
		mwr(4'h3, 16'h1801);
		fe_flags = 16'h0001;
		for (int n = 0; n < 3; n++) begin
			samp(0, (n == 1) ? 5000 : 3000);
			pause(1);
			check(16'(alert_n), 16'(n != 1));
			check(16'(trig_en), 16'h0000);
		end
		// switch with no axis alert enable stays quiet despite a crossing and a status flag
		mwr(4'h3, 16'h1800);
		samp(0, 5000);
		pause(1);
		check(16'(alert_n), 16'h0001);
		fe_flags = 16'h0000;
		mwr(4'h3, 16'h0000);
		pause(1);
		check(16'(trig_en), 16'h0001);
		// temperature limits 32 and 16 codes, one conversion needed
		mwr(4'h7, 16'h2010);
		mwr(4'h3, 16'h0008);
		for (int n = 0; n < 4; n++) begin
			v = (n == 1) ? 48 : (n == 2) ? 8 : 24;
			tcode = 8'(v);
			samp(0, 0);
			pause(1);
			check(16'(alert_n), 16'(v <= 32 && v >= 16));
		end
		// held threshold alert survives the return inside, result read clears it
		mwr(4'h3, 16'h2008);
		for (int n = 0; n < 2; n++) begin
			tcode = n ? 8'h18 : 8'h30;
			samp(0, 0);
			pause(1);
			check(16'(alert_n), 16'h0000);
		end
		u_atl_host_model.clr(2);
		pause(2);
		check(16'(alert_n), 16'h0001);
		mwr(4'h3, 16'h0000);
		tcode = 8'h30;
		samp(0, 0);
		pause(1);
		check(16'(alert_n), 16'h0001);
		final_report();
	end
endmodule // atl_top_test
`default_nettype wire
